/* core/pbm_core.sv */
// Packet buffer, page manager, packet queues, RAM arbiter and host I/O port.
// Assumes host pins are asynchronous to i_clk; the MAC DMA side is on i_clk.
`timescale 1ns/1ps
module pbm_core #(
  parameter int         FDEPTH   = pbm_pkg::FIFO_DEPTH,
  parameter logic [3:0] ROM_SEG  = 4'hC
) (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_io_read_strobe_n,
  input  wire logic        i_io_write_strobe_n,
  input  wire logic        i_byte_high_enable_n,
  input  wire logic [3:0]  i_io_addr,
  input  wire logic [15:0] i_host_data,
  output logic      [15:0] o_host_data,
  output logic             o_host_data_oe_n,
  output logic             o_io_chan_ready,
  input  wire logic        i_mem_read_strobe_n,
  input  wire logic [19:0] i_mem_addr,
  output logic             o_rom_sel_n,
  output logic      [15:0] o_rom_addr,
  input  wire logic        i_cfg_valid,
  input  wire logic [5:0]  i_cfg_addr,
  input  wire logic [15:0] i_cfg_data,
  output logic             o_wide_bus_select,
  input  wire logic        i_dma_req,
  input  wire logic        i_dma_we,
  input  wire logic [4:0]  i_dma_pkt,
  input  wire logic [10:0] i_dma_addr,
  input  wire logic [1:0]  i_dma_be,
  input  wire logic [15:0] i_dma_wdata,
  output logic             o_dma_gnt,
  output logic             o_dma_rvalid,
  output logic      [15:0] o_dma_rdata,
  input  wire logic        i_dma_rready,
  input  wire logic        i_dma_alloc_req,
  input  wire logic [2:0]  i_dma_alloc_pages,
  output logic             o_dma_alloc_ack,
  output logic             o_dma_alloc_done,
  output logic             o_dma_alloc_fail,
  output logic      [4:0]  o_dma_alloc_pkt,
  output logic             o_tx_valid,
  output logic      [4:0]  o_tx_pkt,
  input  wire logic        i_tx_pop,
  input  wire logic        i_rx_push,
  input  wire logic [4:0]  i_rx_pkt,
  output logic             o_rx_ready
);
  localparam int NP = pbm_pkg::PAGES;
  localparam int NK = pbm_pkg::PKTS;

  // Host pins pass two flops; the third stage only remembers strobe levels.
  logic [22:0] hs1_q, hs2_q;
  logic [1:0]  stb_q;
  logic [20:0] rs1_q, rs2_q;
  always_ff @(posedge i_clk) begin
    hs1_q <= {i_io_read_strobe_n, i_io_write_strobe_n, i_byte_high_enable_n,
              i_io_addr, i_host_data};
    hs2_q <= hs1_q;
    stb_q <= hs2_q[22:21];
    rs1_q <= {i_mem_read_strobe_n, i_mem_addr};
    rs2_q <= rs1_q;
    o_rom_sel_n <= rs2_q[20] | (rs2_q[19:16] != ROM_SEG);
    o_rom_addr  <= rs2_q[15:0];
  end

  logic        rd_fall, rd_rise, wr_fall, a0, bhe_n, wide, lo, hi, ok;
  logic [2:0]  idx;
  logic [7:0]  wlo, whi;
  assign rd_fall = !hs2_q[22] && stb_q[1];
  assign rd_rise = hs2_q[22] && !stb_q[1];
  assign wr_fall = !hs2_q[21] && stb_q[0];
  assign bhe_n   = hs2_q[20];
  assign idx     = hs2_q[19:17];
  assign a0      = hs2_q[16];
  assign lo      = !a0;
  assign hi      = wide ? !bhe_n : a0;
  assign ok      = !(wide && a0 && bhe_n);
  assign wlo     = hs2_q[7:0];
  assign whi     = wide ? hs2_q[15:8] : hs2_q[7:0];

  // Host-side state.
  logic [15:0] ptr_q, ptr_d, cfg_q, cfg_d, hrd_q, hrd_d;
  logic [4:0]  sel_q, sel_d;
  logic [1:0]  hl_q, hl_d;
  logic        hr_q, dr_q;
  assign wide = cfg_q[pbm_pkg::CFG_WIDE];

  // Buffer manager state.
  pbm_pkg::pbm_mmu_st_t st_q, st_d;
  logic [NP-1:0] free_q, free_d;
  logic [4:0]    tab_q [NK][pbm_pkg::MAX_PPP];
  logic [4:0]    tab_d [NK][pbm_pkg::MAX_PPP];
  logic [2:0]    cnt_q [NK];
  logic [2:0]    cnt_d [NK];
  logic [4:0]    pkt_q, pkt_d, p_q, p_d, tp, fcnt;
  logic [2:0]    k_q, k_d, n_q, n_d, a_n;
  logic          fail_q, fail_d, own_q, own_d, done;

  // Packet queues and DMA read buffer.
  logic       tx_push, tx_in_rdy, rx_valid, rx_pop;
  logic [4:0] rx_head, hp, r_pkt;
  logic       f_rdy;
  pbm_fifo #(.W(pbm_pkg::QW), .D(NK)) u_txq (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_valid(tx_push), .i_data(sel_q),
    .o_ready(tx_in_rdy), .o_valid(o_tx_valid), .o_data(o_tx_pkt), .i_ready(i_tx_pop));
  pbm_fifo #(.W(pbm_pkg::QW), .D(NK)) u_rxq (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_valid(i_rx_push), .i_data(i_rx_pkt),
    .o_ready(o_rx_ready), .o_valid(rx_valid), .o_data(rx_head), .i_ready(rx_pop));
  logic [15:0] ram_q;
  pbm_fifo #(.W(16), .D(FDEPTH)) u_dmaf (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_valid(dr_q), .i_data(ram_q),
    .o_ready(f_rdy), .o_valid(o_dma_rvalid), .o_data(o_dma_rdata),
    .i_ready(i_dma_rready));

  // Commands written by the host.
  logic       hcmd, hmmu, h_alloc, h_relrx, h_rel, idle, a_go, a_bad, r_go;
  logic [2:0] code;
  assign code    = wlo[7:5];
  assign hcmd    = wr_fall && ok && lo && (idx == pbm_pkg::IO_CMD);
  assign h_alloc = hcmd && (code == pbm_pkg::CMD_ALLOC);
  assign h_relrx = hcmd && (code == pbm_pkg::CMD_REL_RX);
  assign h_rel   = hcmd && (code == pbm_pkg::CMD_REL);
  assign hmmu    = h_alloc || h_relrx || h_rel;
  assign tx_push = hcmd && (code == pbm_pkg::CMD_ENQ);
  assign idle    = (st_q == pbm_pkg::S_IDLE);
  assign fcnt    = 5'($countones(free_q));
  assign a_go    = idle && (h_alloc || (!hmmu && i_dma_alloc_req));
  assign a_n     = h_alloc ? wlo[2:0] : i_dma_alloc_pages;
  assign a_bad   = (a_n == 3'h0) || (a_n > 3'(pbm_pkg::MAX_PPP)) || (fcnt < {2'h0, a_n});
  assign r_go    = idle && ((h_relrx && rx_valid) || h_rel);
  assign r_pkt   = h_relrx ? rx_head : sel_q;
  assign rx_pop  = idle && h_relrx && rx_valid;
  assign o_dma_alloc_ack  = idle && !hmmu && i_dma_alloc_req;
  assign o_dma_alloc_done = done;
  assign o_dma_alloc_fail = fail_q;
  assign o_dma_alloc_pkt  = pkt_q;

  always_comb begin
    st_d = st_q;
    free_d = free_q;
    tab_d = tab_q;
    cnt_d = cnt_q;
    pkt_d = pkt_q;
    k_d = k_q;
    p_d = p_q;
    n_d = n_q;
    fail_d = fail_q;
    own_d = own_q;
    done = 1'b0;
    tp = (k_q == 3'h0) ? p_q : pkt_q;
    case (st_q)
      pbm_pkg::S_IDLE: begin
        if (a_go) begin
          own_d = !h_alloc;
          n_d = a_n;
          if (a_bad) begin
            fail_d = 1'b1;
            done = !h_alloc;
          end else begin
            fail_d = 1'b0;
            k_d = 3'h0;
            p_d = 5'h00;
            st_d = pbm_pkg::S_SCAN;
          end
        end else if (r_go && (cnt_q[r_pkt] != 3'h0)) begin
          pkt_d = r_pkt;
          k_d = 3'h0;
          st_d = pbm_pkg::S_FREE;
        end
      end
      pbm_pkg::S_SCAN: begin
        if (free_q[p_q]) begin
          tab_d[tp][k_q] = p_q;
          free_d[p_q] = 1'b0;
          pkt_d = tp;
          k_d = k_q + 3'h1;
          if (k_q + 3'h1 == n_q) begin
            cnt_d[tp] = n_q;
            done = own_q;
            st_d = pbm_pkg::S_IDLE;
          end
        end
        p_d = p_q + 5'h01;
      end
      pbm_pkg::S_FREE: begin
        free_d[tab_q[pkt_q][k_q]] = 1'b1;
        k_d = k_q + 3'h1;
        if (k_q + 3'h1 == cnt_q[pkt_q]) begin
          cnt_d[pkt_q] = 3'h0;
          st_d = pbm_pkg::S_IDLE;
        end
      end
      default: st_d = pbm_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_q <= pbm_pkg::S_IDLE;
      free_q <= pbm_pkg::FREE_RST;
      tab_q <= '{default: '{default: 5'h00}};
      cnt_q <= '{default: 3'h0};
      pkt_q <= 5'h00;
      k_q <= 3'h0;
      p_q <= 5'h00;
      n_q <= 3'h0;
      fail_q <= 1'b0;
      own_q <= 1'b0;
    end else begin
      st_q <= st_d;
      free_q <= free_d;
      tab_q <= tab_d;
      cnt_q <= cnt_d;
      pkt_q <= pkt_d;
      k_q <= k_d;
      p_q <= p_d;
      n_q <= n_d;
      fail_q <= fail_d;
      own_q <= own_d;
    end
  end

  // RAM port: the host always wins, so its accesses never wait.
  logic [15:0] mem [pbm_pkg::RAM_WORDS];
  logic [4:0]  hpage, dpage;
  logic        hacc, hrd, adv, pg_ok, ram_we;
  logic [1:0]  ram_be;
  logic [11:0] ram_a;
  logic [15:0] ram_wd;
  assign hp     = ptr_q[pbm_pkg::PTR_RX] ? rx_head : sel_q;
  assign hpage  = tab_q[hp][ptr_q[10:8]];
  assign pg_ok  = ptr_q[10:8] < cnt_q[hp];
  assign hacc   = (rd_fall || wr_fall) && ok && pg_ok && (idx == pbm_pkg::IO_DATA);
  assign hrd    = hacc && rd_fall;
  assign dpage  = tab_q[i_dma_pkt][i_dma_addr[10:8]];
  assign o_dma_gnt = i_dma_req && !hacc && (i_dma_we || (f_rdy && !dr_q));
  assign ram_we = hacc ? wr_fall : (o_dma_gnt && i_dma_we);
  assign ram_be = hacc ? {hi, lo} : i_dma_be;
  assign ram_a  = hacc ? {hpage, ptr_q[7:1]} : {dpage, i_dma_addr[7:1]};
  assign ram_wd = hacc ? {whi, wlo} : i_dma_wdata;
  assign adv    = (rd_rise || wr_fall) && ok && hi && ptr_q[pbm_pkg::PTR_AUTO]
                  && (idx == pbm_pkg::IO_DATA);

  always_ff @(posedge i_clk) begin
    if (ram_we && ram_be[0]) begin
      mem[ram_a][7:0] <= ram_wd[7:0];
    end
    if (ram_we && ram_be[1]) begin
      mem[ram_a][15:8] <= ram_wd[15:8];
    end
    ram_q <= mem[ram_a];
  end

  always_comb begin
    ptr_d = ptr_q;
    sel_d = sel_q;
    cfg_d = cfg_q;
    hrd_d = hrd_q;
    hl_d = hl_q;
    if (i_cfg_valid && (i_cfg_addr == pbm_pkg::CFG_WORD)) begin
      cfg_d = i_cfg_data;
    end
    if (wr_fall && ok && (idx == pbm_pkg::IO_PTR)) begin
      if (lo) ptr_d[7:0] = wlo;
      if (hi) ptr_d[15:8] = whi;
    end
    if (wr_fall && ok && lo && (idx == pbm_pkg::IO_SEL)) begin
      sel_d = wlo[4:0];
    end
    if (adv) begin
      ptr_d[10:1] = ptr_q[10:1] + 10'h001;
    end
    if (rd_fall) begin
      hl_d = {!wide && a0, !wide};
    end
    if (hr_q) begin
      hrd_d = hl_q[1] ? {8'h00, ram_q[15:8]} : (hl_q[0] ? {8'h00, ram_q[7:0]} : ram_q);
    end else if (rd_fall) begin
      case (idx)
        pbm_pkg::IO_PTR: hrd_d = ptr_q;
        pbm_pkg::IO_RES: hrd_d = {fail_q, !idle, 9'h000, pkt_q};
        pbm_pkg::IO_SEL: hrd_d = {11'h000, sel_q};
        pbm_pkg::IO_RXH: hrd_d = {!rx_valid, !tx_in_rdy, 9'h000, rx_head};
        default:         hrd_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ptr_q <= 16'h0000;
      sel_q <= 5'h00;
      cfg_q <= pbm_pkg::CFG_RST;
      hrd_q <= 16'h0000;
      hl_q <= 2'h0;
      hr_q <= 1'b0;
      dr_q <= 1'b0;
    end else begin
      ptr_q <= ptr_d;
      sel_q <= sel_d;
      cfg_q <= cfg_d;
      hrd_q <= hrd_d;
      hl_q <= hl_d;
      hr_q <= hrd;
      dr_q <= o_dma_gnt && !i_dma_we;
    end
  end

  assign o_host_data       = hrd_q;
  assign o_host_data_oe_n  = hs2_q[22];
  assign o_io_chan_ready   = 1'b1;
  assign o_wide_bus_select = wide;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_alloc_ok;
    idle && a_go && !a_bad;
  endsequence
  // A scan may end on the last page, one cycle per page, then one more cycle to return.
  sequence s_back_idle;
    ##[1:25] (st_q == pbm_pkg::S_IDLE);
  endsequence

  chan_ready_a: assert property (o_io_chan_ready)
    else $error("wait output negated");
  host_excl_a: assert property (hacc |-> !o_dma_gnt)
    else $error("dma granted during host access");
  alloc_fail_a: assert property (idle && a_go && (fcnt < {2'h0, a_n}) |=> fail_q && idle)
    else $error("short allocation not refused");
  alloc_bound_a: assert property (s_alloc_ok |-> s_back_idle)
    else $error("allocation did not finish");
  alloc_pages_a: assert property (s_alloc_ok ##1 s_back_idle |-> cnt_q[pkt_q] == n_q)
    else $error("allocated page count wrong");
  byte_lane_a: assert property (hr_q && hl_q[1] |=> o_host_data[7:0] == $past(ram_q[15:8]))
    else $error("odd byte not on low lane");
  bad_cycle_a: assert property (wr_fall && wide && a0 && bhe_n |-> !hacc && !(ram_we && !o_dma_gnt))
    else $error("invalid cycle wrote RAM");
  auto_inc_a: assert property (adv |=> ptr_q[10:1] == $past(ptr_q[10:1]) + 10'h001)
    else $error("pointer did not advance");
  dma_read_a: assert property (o_dma_gnt && !i_dma_we |=> dr_q ##1 !dr_q)
    else $error("dma read not buffered");
endmodule // pbm_core

/* core/pbm_pkg.sv */
// Constants, encodings and types of the packet buffer and its host port.
// Assumes one 250 MHz system clock; nothing here holds logic.
package pbm_pkg;
  localparam int RAM_BYTES  = 6144;
  localparam int PAGE_BYTES = 256;
  localparam int RAM_WORDS  = RAM_BYTES / 2;
  localparam int PAGES      = RAM_BYTES / PAGE_BYTES;
  localparam int PKTS       = 24;
  localparam int MAX_PPP    = 6;
  localparam int QW         = 5;
  localparam int IO_LOCS    = 16;
  localparam int EE_WORDS   = 64;
  localparam int FIFO_DEPTH = 8;
  // Host I/O locations, indexed by address bits 3..1.
  localparam logic [2:0] IO_PTR  = 3'h0;
  localparam logic [2:0] IO_DATA = 3'h1;
  localparam logic [2:0] IO_CMD  = 3'h2;
  localparam logic [2:0] IO_RES  = 3'h3;
  localparam logic [2:0] IO_SEL  = 3'h4;
  localparam logic [2:0] IO_RXH  = 3'h5;
  // Pointer fields.
  localparam int PTR_RX   = 15;
  localparam int PTR_AUTO = 14;
  // Configuration word and its bus-width bit.
  localparam int           CFG_WIDE = 7;
  localparam logic [5:0]   CFG_WORD = 6'h00;
  localparam logic [15:0]  CFG_RST  = 16'h0080;
  localparam logic [23:0]  FREE_RST = 24'hFF_FFFF;
  // Buffer manager and transmit queue commands, data bits 7..5; page count in bits 2..0.
  localparam logic [2:0] CMD_ALLOC  = 3'h1;
  localparam logic [2:0] CMD_REL_RX = 3'h2;
  localparam logic [2:0] CMD_REL    = 3'h3;
  localparam logic [2:0] CMD_ENQ    = 3'h4;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_SCAN = 2'b01,
    S_FREE = 2'b11
  } pbm_mmu_st_t;
endpackage

/* core/pbm_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and synchronous active-high reset.
`timescale 1ns/1ps
module pbm_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_sys_rst,
  input  wire logic         i_valid,
  input  wire logic [W-1:0] i_data,
  output logic              o_ready,
  output logic              o_valid,
  output logic [W-1:0]      o_data,
  input  wire logic         i_ready
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);
  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic          push, pop;

  assign o_ready = (cnt_q != CW'(D));
  assign o_valid = (cnt_q != '0);
  assign o_data  = mem_q[rp_q];
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;

  always_comb begin
    wp_d  = wp_q;
    rp_d  = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      wp_d = (wp_q == AW'(D - 1)) ? '0 : wp_q + AW'(1);
    end
    if (pop) begin
      rp_d = (rp_q == AW'(D - 1)) ? '0 : rp_q + AW'(1);
    end
    if (push && !pop) begin
      cnt_d = cnt_q + CW'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - CW'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wp_q] <= i_data;
    end
  end
endmodule // pbm_fifo

/* sim/pbm_host_model.sv */
// Host CPU model: runs one byte or word I/O cycle on the local bus pins per call.
// Assumes the bench feeds i_bus with the resolved data bus and waits out each call.
`timescale 1ns/1ps
module pbm_host_model (
  input  wire logic        i_clk,
  input  wire logic [15:0] i_bus,
  output logic             o_rd_n,
  output logic             o_wr_n,
  output logic             o_bhe_n,
  output logic [3:0]       o_addr,
  output logic [15:0]      o_data
);
  initial begin
    o_rd_n  = 1'b1;
    o_wr_n  = 1'b1;
    o_bhe_n = 1'b0;
    o_addr  = 4'h0;
    o_data  = 16'hFFFF;
  end

  // Address, lanes and data settle before the strobe and stay until it has risen.
  task automatic cycle(input logic we, input logic [3:0] a, input logic b,
                       input logic [15:0] d, output logic [15:0] q);
    @(posedge i_clk);
    #1;
    o_addr  = a;
    o_bhe_n = b;
    if (we) o_data = d;
    repeat (4) @(posedge i_clk);
    #1;
    if (we) o_wr_n = 1'b0;
    else o_rd_n = 1'b0;
    repeat (6) @(posedge i_clk);
    q = i_bus;
    #1;
    o_wr_n = 1'b1;
    o_rd_n = 1'b1;
    repeat (4) @(posedge i_clk);
    #1;
    // A released bus shows the inverse of its last value, never a stale copy.
    o_data = ~o_data;
  endtask
endmodule // pbm_host_model

/* sim/pbm_core_tb.sv */
// Self-checking bench for the packet buffer core; it plays the DMA side itself.
// Assumes pbm_host_model drives the host pins and the bench resolves the data bus.
`timescale 1ns/1ps
module pbm_core_tb;
  localparam logic [3:0] A_PTR = {pbm_pkg::IO_PTR, 1'b0};
  localparam logic [3:0] A_DAT = {pbm_pkg::IO_DATA, 1'b0};
  localparam logic [3:0] A_SEL = {pbm_pkg::IO_SEL, 1'b0};
  localparam logic [3:0] A_RXH = {pbm_pkg::IO_RXH, 1'b0};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        rd_n, wr_n, bhe_n, oe_n, rdy, mrd_n, rom_n, cfg_v, wide, dreq, dwe, gnt, rv;
  logic        rrdy, areq, aack, adone, afail, txv, txpop, rxpush, rxr;
  logic [3:0]  addr;
  logic [15:0] hdat, hout, bus, romaddr, cfg_d, dwd, rdat, r;
  logic [19:0] maddr;
  logic [5:0]  cfg_a, e;
  logic [10:0] daddr;
  logic [4:0]  dpkt, apkt, txp, rxp;
  logic [1:0]  dbe;
  logic [2:0]  apg;
  logic [15:0] w [0:3];
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          fr = 24;
  int          nx = 0;
  int          cnt;
  bit          ok;

  always #2 clk = ~clk;
  assign bus = oe_n ? hdat : hout;

  pbm_host_model i_pbm_host_model (.i_clk(clk), .i_bus(bus), .o_rd_n(rd_n), .o_wr_n(wr_n),
    .o_bhe_n(bhe_n), .o_addr(addr), .o_data(hdat));

  pbm_core i_pbm_core (.i_clk(clk), .i_sys_rst(rst), .i_io_read_strobe_n(rd_n),
    .i_io_write_strobe_n(wr_n), .i_byte_high_enable_n(bhe_n), .i_io_addr(addr),
    .i_host_data(bus), .o_host_data(hout), .o_host_data_oe_n(oe_n), .o_io_chan_ready(rdy),
    .i_mem_read_strobe_n(mrd_n), .i_mem_addr(maddr), .o_rom_sel_n(rom_n),
    .o_rom_addr(romaddr), .i_cfg_valid(cfg_v), .i_cfg_addr(cfg_a), .i_cfg_data(cfg_d),
    .o_wide_bus_select(wide), .i_dma_req(dreq), .i_dma_we(dwe), .i_dma_pkt(dpkt),
    .i_dma_addr(daddr), .i_dma_be(dbe), .i_dma_wdata(dwd), .o_dma_gnt(gnt),
    .o_dma_rvalid(rv), .o_dma_rdata(rdat), .i_dma_rready(rrdy), .i_dma_alloc_req(areq),
    .i_dma_alloc_pages(apg), .o_dma_alloc_ack(aack), .o_dma_alloc_done(adone),
    .o_dma_alloc_fail(afail), .o_dma_alloc_pkt(apkt), .o_tx_valid(txv), .o_tx_pkt(txp),
    .i_tx_pop(txpop), .i_rx_push(rxpush), .i_rx_pkt(rxp), .o_rx_ready(rxr));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic b = 1'b0);
    logic [15:0] q;
    i_pbm_host_model.cycle(1'b1, a, b, d, q);
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] q, input logic b = 1'b0);
    i_pbm_host_model.cycle(1'b0, a, b, 16'h0000, q);
  endtask

  task automatic mmu(input logic [7:0] c);
    wr({pbm_pkg::IO_CMD, 1'b0}, {8'h00, c});
    for (int k = 0; k < 8; k++) begin
      rd({pbm_pkg::IO_RES, 1'b0}, r);
      if (r[14] !== 1'b1) break;
    end
  endtask

  // Holds the request until a sampled grant or for six cycles at most; a spare cycle keeps reads two apart.
  task automatic dma(input logic we, input logic [10:0] a, input logic [15:0] d);
    dwe = we;
    daddr = a;
    dwd = d;
    dreq = 1'b1;
    ok = 1'b0;
    for (int k = 0; k < 6 && !ok; k++) begin
      #2;
      ok = (gnt === 1'b1);
      tick(1);
    end
    dreq = 1'b0;
    tick(1);
  endtask

  // Expected page request result: fail flag over packet number, lowest free page first.
  function automatic logic [5:0] alloc_exp(input int n);
    if (n == 0 || n > pbm_pkg::MAX_PPP || n > fr) return 6'h20;
    fr -= n;
    nx += n;
    return 6'(nx - n);
  endfunction

  task automatic cfg(input logic [15:0] d);
    cfg_a = pbm_pkg::CFG_WORD;
    cfg_d = d;
    cfg_v = 1'b1;
    tick(1);
    cfg_v = 1'b0;
    tick(3);
  endtask

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #80000;
    n_mismatch++;
    print_verdict();
  end

  initial begin
    {mrd_n, maddr, cfg_v, cfg_a, cfg_d, dreq, dwe, dpkt, daddr, dwd} = '1;
    {cfg_v, dreq, rrdy, areq, apg, txpop, rxpush, rxp, dpkt} = '0;
    dbe = 2'b11;
    void'($urandom(96));
    tick(20);
    rst = 1'b0;
    tick(2);
    chk(rdy, 1'b1);
    chk(wide, 1'b1);
    chk(hout, 16'h0000);
    mrd_n = 1'b0;
    maddr = 20'hC_1234;
    tick(4);
    chk({rom_n, romaddr}, {1'b0, 16'h1234});
    maddr = 20'hD_0000;
    tick(4);
    chk(rom_n, 1'b1);
    mrd_n = 1'b1;
    $display("test reset_rom done");
    foreach (w[k]) w[k] = 16'($urandom);
    for (int k = 0; k < 9; k++) begin
      cnt = (k == 0) ? 0 : (k == 1) ? 7 : (k < 5) ? 6 : (k == 5) ? 5 : (k == 6) ? 2 : 1;
      e = alloc_exp(cnt);
      mmu(8'h20 | 8'(cnt));
      chk({r[15], r[15] ? 5'h00 : r[4:0]}, {e[5], e[4:0]});
    end
    $display("test alloc done");
    wr(A_SEL, 16'h0000);
    wr(A_PTR, 16'h40FC);
    foreach (w[k]) wr(A_DAT, w[k]);
    wr(A_PTR, 16'h40FC);
    wr(A_DAT + 4'h1, ~w[0], 1'b1);
    foreach (w[k]) begin
      rd(k == 0 ? A_DAT : A_DAT, r);
      chk(r, w[k]);
    end
    wr(A_PTR, 16'h40FC);
    wr(A_DAT + 4'h1, 16'hA55A);
    wr(A_DAT, 16'h3CC3, 1'b1);
    w[0][15:8] = 8'hA5;
    w[1][7:0] = 8'hC3;
    dma(1'b1, 11'h102, 16'h9E11);
    w[3] = 16'h9E11;
    wr(A_PTR, 16'h40FC);
    foreach (w[k]) begin
      rd(A_DAT, r);
      chk(r, w[k]);
    end
    $display("test host_data done");
    for (int k = 0; k < 9; k++) begin
      dma(1'b0, 11'h0FC + 11'(2 * (k % 4)), 16'h0000);
      chk(ok, k < 8);
    end
    cnt = 0;
    for (int k = 0; k < 60; k++) begin
      rrdy = 1'($urandom_range(0, 1));
      #2;
      if (rv === 1'b1 && rrdy) begin
        chk(rdat, w[cnt % 4]);
        cnt++;
      end
      tick(1);
    end
    rrdy = 1'b0;
    chk(16'(cnt), 16'd8);
    chk(rv, 1'b0);
    $display("test dma_fifo done");
    wr(A_PTR, 16'h40FC);
    cfg(16'h0000);
    chk(wide, 1'b0);
    rd(A_DAT, r, 1'b1);
    chk(r[7:0], w[0][7:0]);
    rd(A_DAT + 4'h1, r);
    chk(r[7:0], w[0][15:8]);
    rd(A_DAT, r);
    chk(r[7:0], w[1][7:0]);
    cfg(pbm_pkg::CFG_RST);
    chk(wide, 1'b1);
    $display("test byte_mode done");
    mmu(8'h80);
    tick(2);
    chk({txv, txp}, {1'b1, 5'h00});
    txpop = 1'b1;
    tick(1);
    txpop = 1'b0;
    tick(1);
    chk(txv, 1'b0);
    rxp = 5'h06;
    rxpush = 1'b1;
    ok = 1'b0;
    for (int k = 0; k < 8 && !ok; k++) begin
      #2;
      ok = (rxr === 1'b1);
      tick(1);
    end
    rxpush = 1'b0;
    rd(A_RXH, r);
    chk(r[4:0], 5'h06);
    mmu(8'h40);
    mmu(8'h26);
    chk({r[15], r[4:0]}, {1'b0, 5'h06});
    // Free packets 12 and 18, so the DMA request gets packet 12, not the last one released.
    wr(A_SEL, 16'h000C);
    mmu(8'h60);
    wr(A_SEL, 16'h0012);
    mmu(8'h60);
    for (int j = 0; j < 2; j++) begin
      apg = (j == 0) ? 3'h2 : 3'h7;
      areq = 1'b1;
      ok = 1'b0;
      for (int k = 0; k < 40 && !ok; k++) begin
        bit tk;
        #2;
        tk = (aack === 1'b1);
        ok = (adone === 1'b1);
        tick(1);
        if (tk) areq = 1'b0;
      end
      chk({ok, afail, apkt}, {1'b1, 1'(j), 5'h0C});
    end
    $display("test queues done");
    print_verdict();
  end
endmodule // pbm_core_tb
